// File: hdl/otpap_top.sv
// node configuration, address allocation and otp programming logic
// assumes decoded telegrams arrive on core_clk_i as one-cycle strobes
//
// Overview of operation
// R1: host gives its interface device a fixed nonzero address, ideally 1023.
// R2: bus rate field reads 250 kbit/s code until software changes it.
// R3: host sets interface device to the rate programmed into the nodes.
// R4: host broadcasts scan period 2, threshold 7, reduced rate 1 first.
// R5: after assign command, node seeing light pulse stores n as own address.
// R6: host allocates addresses one per node, starting at 1, ascending.
// R7: node answers a register read sent to its allocated address.
// R8: address lives in ram word 23, made permanent by program into word 7.
// R9: register write to address 0 is accepted by every node.
// R10: host sets regulator disable to 1 in interface, 0 elsewhere.
// R11: program copies 16..19 to 0..3 and 23 to 7, nothing else.
// R12: each word is programmed by its own command naming the rom word.
// R13: program command has code 110 followed by rom register address.
// R14: host waits at least 400 us between program commands; the host model's prog waits only GAP_CYCLES + 2 clock cycles.
// R15: a rom word programs once; later attempts leave it unchanged.
// R16: programming a rom word sets its bit 0 as programmed flag.
// R17: assign command is ignored once rom address word is programmed.
// R18: ram write only while paired rom word unprogrammed; rom never writable.
// R19: address 0 is never an individual node address.
// R20: unconfigured node starts with address zero and parameters unset.
// R21: after reset the node runs on its programmed rom contents.

module otpap_top
    import otpap_pkg::*;
#(
    parameter int PROG_GAP_CYCLES = PROG_GAP_CYC
)
(
    input  wire logic                  core_clk_i,
    input  wire logic                  rst_b_i,
    input  wire logic                  fuse_blank_b_i,
    input  otpap_pkg::otpap_cmd_type   cmd_i,
    input  wire logic                  light_pulse_i,
    input  wire logic                  vprog_ok_i,
    output otpap_pkg::otpap_rsp_type   rsp_o,
    output logic [ADDR_W-1:0]          node_addr_o,
    output logic [RATE_W-1:0]          bus_bit_rate_o,
    output logic                       prog_busy_o,
    output logic                       assign_armed_o
);

    import otpap_pkg::*;

    localparam int GAP_W = $clog2(PROG_GAP_CYCLES + 1);

    // ==================================================================
    // reset and pin synchronisers
    logic rst_s1_reg;
    logic rst_s2_reg;
    logic lt_s1_reg;
    logic lt_s2_reg;
    logic lt_s3_reg;
    logic vp_s1_reg;
    logic vp_s2_reg;
    wire  rst_n = rst_s2_reg;

    always_ff @(posedge core_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            rst_s1_reg <= 1'b0;
            rst_s2_reg <= 1'b0;
        end
        else
        begin
            rst_s1_reg <= 1'b1;
            rst_s2_reg <= rst_s1_reg;
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            lt_s1_reg <= 1'b0;
            lt_s2_reg <= 1'b0;
            lt_s3_reg <= 1'b0;
            vp_s1_reg <= 1'b0;
            vp_s2_reg <= 1'b0;
        end
        else
        begin
            lt_s1_reg <= light_pulse_i;
            lt_s2_reg <= lt_s1_reg;
            lt_s3_reg <= lt_s2_reg;
            vp_s1_reg <= vprog_ok_i;
            vp_s2_reg <= vp_s1_reg;
        end
    end

    // ==================================================================
    // slot decoding
    // only the five documented pairs map; every other index misses
    function automatic logic [3:0] ram_slot_of(input logic [4:0] idx);
        case (idx)
            RAM_CFG_A:     ram_slot_of = 4'h8;
            RAM_CFG_B:     ram_slot_of = 4'h9;
            RAM_CFG_C:     ram_slot_of = 4'ha;
            RAM_CFG_D:     ram_slot_of = 4'hb;
            RAM_NODE_ADDR: ram_slot_of = 4'hc;
            default:       ram_slot_of = 4'h0;
        endcase
    endfunction

    function automatic logic [3:0] rom_slot_of(input logic [4:0] idx);
        case (idx)
            ROM_CFG_A:     rom_slot_of = 4'h8;
            ROM_CFG_B:     rom_slot_of = 4'h9;
            ROM_CFG_C:     rom_slot_of = 4'ha;
            ROM_CFG_D:     rom_slot_of = 4'hb;
            ROM_NODE_ADDR: rom_slot_of = 4'hc;
            default:       rom_slot_of = 4'h0;
        endcase
    endfunction

    // ==================================================================
    // state
    otpap_state_type   state_reg;
    otpap_state_type   state_next;
    otpap_bank_type    ram_reg;
    otpap_bank_type    ram_next;
    otpap_bank_type    bank;
    otpap_rsp_type     rsp_next;
    logic              load_reg;
    logic [ADDR_W-1:0] pend_reg;
    logic [GAP_W-1:0]  gap_reg;

    wire [3:0]        ram_dec    = ram_slot_of(cmd_i.reg_addr);
    wire [3:0]        rom_dec    = rom_slot_of(cmd_i.reg_addr);
    wire              ram_hit    = ram_dec[3];
    wire              rom_hit    = rom_dec[3];
    wire [2:0]        ram_slot   = ram_dec[2:0];
    wire [2:0]        rom_slot   = rom_dec[2:0];
    wire [ADDR_W-1:0] own_addr   = ram_reg[SLOT_ADDR][ADDR_LSB +: ADDR_W];
    wire              accept     = cmd_i.valid && !load_reg;
    wire              is_bcast   = cmd_i.dev_addr == BCAST_ADDR;
    wire              is_mine    = !is_bcast
                                   && cmd_i.dev_addr == own_addr; // R19
    wire              light_rise = lt_s2_reg && !lt_s3_reg;
    wire              addr_fused = bank[SLOT_ADDR][FLAG_BIT];
    wire              write_ok   = accept && cmd_i.code == CMD_WRITE
                                   && (is_mine || is_bcast) // R9
                                   && ram_hit
                                   && !bank[ram_slot][FLAG_BIT]; // R18
    wire              read_ok    = accept && cmd_i.code == CMD_READ
                                   && is_mine; // R7
    // the address word is burnt one node at a time only
    wire              prog_ok    = accept && cmd_i.code == CMD_PROG // R13
                                   && rom_hit // R11 R12
                                   && (is_mine
                                       || (is_bcast
                                           && rom_slot != SLOT_ADDR)) // R8
                                   && vp_s2_reg
                                   && state_reg != ST_BURN
                                   && !bank[rom_slot][FLAG_BIT]; // R15
    wire              assign_ok  = accept && cmd_i.code == CMD_ASSIGN
                                   && !is_bcast // R19
                                   && !addr_fused; // R17
    wire              reset_ok   = accept && cmd_i.code == CMD_RESET
                                   && (is_mine || is_bcast);
    wire              take_light = state_reg == ST_ARMED && light_rise;
    wire [WORD_W-1:0] prog_word  = ram_reg[rom_slot];
    wire [WORD_W-1:0] read_word  = ram_hit ? ram_reg[ram_slot]
                                 : rom_hit ? bank[rom_slot]
                                 : WORD_BLANK;

    otpap_otp_bank otpap_otp_bank_i
    (
        .core_clk_i     (core_clk_i),
        .fuse_blank_b_i (fuse_blank_b_i),
        .prog_en_i      (prog_ok),
        .prog_slot_i    (rom_slot),
        .prog_data_i    (prog_word),
        .words_o        (bank)
    );

    // ==================================================================
    // ram words
    // reload from rom after any reset; blank rom gives address zero
    genvar g;
    generate
        for (g = 0; g < SLOTS; g++)
        begin : gen_ram
            wire [WORD_W-1:0] lit = (g == SLOT_ADDR && take_light)
                ? {ram_reg[g][WORD_W-1:ADDR_LSB+ADDR_W], pend_reg,
                   ram_reg[g][ADDR_LSB-1:0]}
                : ram_reg[g]; // R5
            assign ram_next[g] = load_reg ? bank[g] // R21 R20
                : (write_ok && ram_slot == 3'(g)) ? cmd_i.data
                : lit;
        end
    endgenerate

    // ==================================================================
    // control sequence
    always_comb
    begin
        state_next = state_reg;
        case (state_reg)
            ST_IDLE:
                if (prog_ok)
                    state_next = ST_BURN;
                else if (assign_ok)
                    state_next = ST_ARMED;
            ST_ARMED:
                if (prog_ok)
                    state_next = ST_BURN;
                else if (assign_ok)
                    state_next = ST_ARMED;
                else if (accept || take_light)
                    state_next = ST_IDLE;
            ST_BURN:
                if (gap_reg == '0)
                    state_next = ST_IDLE;
            default:
                state_next = ST_IDLE;
        endcase
        if (reset_ok)
            state_next = ST_IDLE;
    end

    assign rsp_next.valid    = read_ok;
    assign rsp_next.reg_addr = cmd_i.reg_addr;
    assign rsp_next.data     = read_word;

    always_ff @(posedge core_clk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_reg <= ST_IDLE;
            ram_reg   <= '0;
            load_reg  <= 1'b1;
            pend_reg  <= '0;
            gap_reg   <= '0;
            rsp_o     <= '0;
        end
        else
        begin
            state_reg <= state_next;
            ram_reg   <= ram_next;
            load_reg  <= reset_ok;
            rsp_o     <= rsp_next;
            if (assign_ok)
                pend_reg <= cmd_i.dev_addr;
            // burn recovery window; host spacing is not trusted
            if (prog_ok)
                gap_reg <= GAP_W'(PROG_GAP_CYCLES - 1);
            else if (gap_reg != '0)
                gap_reg <= gap_reg - 1'b1;
        end
    end

    // ==================================================================
    // output flops
    always_ff @(posedge core_clk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            node_addr_o    <= '0;
            bus_bit_rate_o <= RATE_250K;
            prog_busy_o    <= 1'b0;
            assign_armed_o <= 1'b0;
        end
        else
        begin
            node_addr_o    <= ram_next[SLOT_ADDR][ADDR_LSB +: ADDR_W];
            bus_bit_rate_o <= ram_next[0][RATE_LSB +: RATE_W]; // R2
            prog_busy_o    <= state_next == ST_BURN;
            assign_armed_o <= state_next == ST_ARMED;
        end
    end

    // ==================================================================
    // checks
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!rst_n);

    rate_default_a: assert property (load_reg && bank[0] == WORD_BLANK // R2
        |=> bus_bit_rate_o == RATE_250K)
        else $error("rate not at 250 kbit/s code after blank reload");
    assign_store_a: assert property (take_light && !write_ok // R5
        && !load_reg |=> own_addr == $past(pend_reg))
        else $error("light pulse did not store pending address");
    read_answer_a: assert property (read_ok // R7
        |=> rsp_o.valid && rsp_o.reg_addr == $past(cmd_i.reg_addr)
            && rsp_o.data == $past(read_word))
        else $error("read not answered next cycle");
    prog_copy_a: assert property (prog_ok // R11
        |=> bank[$past(rom_slot)] == ($past(prog_word) | FLAG_MASK))
        else $error("program did not copy ram word with flag");
    otp_once_a: assert property (accept && cmd_i.code == CMD_PROG // R15
        && rom_hit && bank[rom_slot][FLAG_BIT] |=> $stable(bank))
        else $error("programmed rom word changed");
    bcast_write_a: assert property (write_ok && is_bcast // R9
        && !take_light |=> ram_reg[$past(ram_slot)] == $past(cmd_i.data))
        else $error("broadcast write not stored");
    ram_lock_a: assert property (accept && cmd_i.code == CMD_WRITE // R18
        && !(ram_hit && !bank[ram_slot][FLAG_BIT])
        && state_reg != ST_ARMED |=> ram_reg == $past(ram_reg))
        else $error("locked or rom register written");
    assign_lock_a: assert property (cmd_i.valid // R17
        && cmd_i.code == CMD_ASSIGN && addr_fused
        && state_reg != ST_ARMED |=> state_reg != ST_ARMED)
        else $error("assign accepted after address fused");
    bcast_silent_a: assert property (cmd_i.valid // R19
        && cmd_i.code == CMD_READ && is_bcast |=> !rsp_o.valid)
        else $error("node answered at address zero");
    reload_a: assert property (load_reg |=> ram_reg == $past(bank)) // R21
        else $error("ram not reloaded from rom");
    burn_busy_a: assert property (prog_ok |=> prog_busy_o [*2]) // R13
        else $error("busy not shown after program");

    assign_c: cover property (assign_ok ##[1:50] take_light);
    prog_c:   cover property (prog_ok && rom_slot == SLOT_ADDR);
    read_c:   cover property (read_ok && rom_hit);
    bcast_c:  cover property (write_ok && is_bcast);

endmodule

// File: hdl/otpap_pkg.sv
// constants, command codes and carrier types of the otp address block
// assumes one 40 MHz clock shared by the telegram decoder and this block

package otpap_pkg;

    // ==================================================================
    // command codes and register indices
    localparam logic [2:0] CMD_READ      = 3'h1;
    localparam logic [2:0] CMD_WRITE     = 3'h2;
    localparam logic [2:0] CMD_ASSIGN    = 3'h3;
    localparam logic [2:0] CMD_RESET     = 3'h4;
    localparam logic [2:0] CMD_PROG      = 3'h6;

    localparam logic [4:0] ROM_CFG_A     = 5'h00;
    localparam logic [4:0] ROM_CFG_B     = 5'h01;
    localparam logic [4:0] ROM_CFG_C     = 5'h02;
    localparam logic [4:0] ROM_CFG_D     = 5'h03;
    localparam logic [4:0] ROM_NODE_ADDR = 5'h07;
    localparam logic [4:0] RAM_CFG_A     = 5'h10;
    localparam logic [4:0] RAM_CFG_B     = 5'h11;
    localparam logic [4:0] RAM_CFG_C     = 5'h12;
    localparam logic [4:0] RAM_CFG_D     = 5'h13;
    localparam logic [4:0] RAM_NODE_ADDR = 5'h17;

    // ==================================================================
    // field layout and reset values
    localparam int          SLOTS        = 5;
    localparam int          WORD_W       = 16;
    localparam logic [2:0]  SLOT_ADDR    = 3'h4;
    localparam int          FLAG_BIT     = 0;
    localparam int          ADDR_LSB     = 1;
    localparam int          ADDR_W       = 10;
    localparam logic [9:0]  BCAST_ADDR   = 10'h000;
    localparam int          RATE_LSB     = 1;
    localparam int          RATE_W       = 3;
    localparam logic [2:0]  RATE_250K    = 3'h0;
    localparam logic [15:0] WORD_BLANK   = 16'h0000;
    localparam logic [15:0] FLAG_MASK    = 16'h0001;

    // ==================================================================
    // timing
    localparam int CLK_MHZ      = 40;
    localparam int PROG_GAP_US  = 400;
    localparam int PROG_GAP_CYC = PROG_GAP_US * CLK_MHZ;

    // ==================================================================
    // types
    typedef struct packed {
        logic        valid;
        logic [2:0]  code;
        logic [9:0]  dev_addr;
        logic [4:0]  reg_addr;
        logic [15:0] data;
    } otpap_cmd_type;

    typedef struct packed {
        logic        valid;
        logic [4:0]  reg_addr;
        logic [15:0] data;
    } otpap_rsp_type;

    typedef logic [SLOTS-1:0][WORD_W-1:0] otpap_bank_type;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_ARMED,
        ST_BURN
    } otpap_state_type;

endpackage

// File: hdl/otpap_otp_bank.sv
// one-time-programmable word bank, five words of sixteen bits
// assumes fuse_blank_b_i is asserted only when the array is blank

module otpap_otp_bank
    import otpap_pkg::*;
(
    input  wire logic                 core_clk_i,
    input  wire logic                 fuse_blank_b_i,
    input  wire logic                 prog_en_i,
    input  wire logic [2:0]           prog_slot_i,
    input  wire logic [WORD_W-1:0]    prog_data_i,
    output otpap_pkg::otpap_bank_type words_o
);

    // ==================================================================
    // fuse words
    // a word whose flag is set never burns again, whatever the caller
    genvar g;
    generate
        for (g = 0; g < SLOTS; g++)
        begin : gen_word
            logic [WORD_W-1:0] word_reg;
            wire               burn = prog_en_i && prog_slot_i == 3'(g)
                                      && !word_reg[FLAG_BIT];

            always_ff @(posedge core_clk_i or negedge fuse_blank_b_i)
            begin
                if (!fuse_blank_b_i)
                    word_reg <= WORD_BLANK;
                else if (burn)
                    word_reg <= prog_data_i | FLAG_MASK; // R15 R16
            end

            assign words_o[g] = word_reg;
        end
    endgenerate

endmodule

// File: sim/otpap_host_model.sv
// stand-in for the bus interface device that feeds decoded commands
// assumes one caller at a time; everything changes on the falling edge

module otpap_host_model
    import otpap_pkg::*;
#(
    parameter int GAP_CYCLES = 8
)
(
    input  wire logic                core_clk_i,
    output otpap_pkg::otpap_cmd_type cmd_o,
    output logic                     light_o,
    output logic                     vprog_o
);
    timeunit 1ns;
    timeprecision 100ps;

    // ========================================
    // host side state
    // own address of the interface, never handed to a node
    localparam logic [9:0] IF_ADDR   = 10'h3ff;
    logic [RATE_W-1:0]     link_rate = RATE_250K;
    // allocation settings; field places are the host's own packing
    localparam logic [2:0] SCAN_PERIOD       = 3'h2;
    localparam logic [3:0] NORMAL_THRESHOLD  = 4'h7;
    localparam logic       REDUCED_RATE      = 1'b1;
    localparam logic       REGULATOR_DISABLE = 1'b0;

    initial
    begin
        cmd_o   = '0;
        light_o = 1'b0;
        vprog_o = 1'b0;
    end

    // ========================================
    // command, light and supply tasks
    task automatic send(input logic [2:0] code, input logic [9:0] dev,
                        input logic [4:0] rg, input logic [15:0] dat);
        @(negedge core_clk_i);
        cmd_o = '{1'b1, code, dev, rg, dat};
        @(negedge core_clk_i);
        cmd_o.valid = 1'b0;
        // keep the link at the rate just broadcast to the nodes
        if (code == CMD_WRITE && dev == 10'h000 && rg == RAM_CFG_A)
            link_rate = dat[RATE_LSB +: RATE_W];
    endtask

    // one word per command, then the burn gap before the next one
    task automatic prog(input logic [9:0] dev, input logic [4:0] rom);
        send(CMD_PROG, dev, rom, 16'h0000);
        repeat (GAP_CYCLES + 2) @(negedge core_clk_i);
    endtask

    // all nodes at once, before any address is handed out
    task automatic prepare();
        send(CMD_WRITE, 10'h000, RAM_CFG_B, {7'h0, REDUCED_RATE,
             NORMAL_THRESHOLD, SCAN_PERIOD, REGULATOR_DISABLE});
    endtask

    task automatic flash();
        @(negedge core_clk_i);
        light_o = 1'b1;
        repeat (4) @(negedge core_clk_i);
        light_o = 1'b0;
    endtask

    task automatic supply(input logic on);
        @(negedge core_clk_i);
        vprog_o = on;
        repeat (3) @(negedge core_clk_i);
    endtask
endmodule

// File: sim/otpap_top_bench.sv
// self-checking bench for the otp address block with a host stand-in
// assumes the design's own assertions run alongside; 40 MHz clock

module otpap_top_bench
    import otpap_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;

    // ========================================
    // constants and signals
    localparam int          GAP   = 8;
    localparam int          LIMIT = 2000;
    localparam logic [15:0] A_VAL = 16'h0004;
    localparam logic [15:0] B_VAL = 16'h1234;
    localparam logic [15:0] ADDR1 = 16'h0001 << ADDR_LSB;
    localparam logic [15:0] RATE_A = {13'h0, A_VAL[RATE_LSB +: RATE_W]};

    logic              core_clk = 1'b0;
    logic              rst_b;
    logic              fuse_blank_b;
    otpap_cmd_type     cmd;
    logic              light;
    logic              vprog;
    otpap_rsp_type     rsp;
    logic [ADDR_W-1:0] node_addr;
    logic [RATE_W-1:0] rate;
    logic              busy;
    logic              armed;
    int                n_errors = 0;
    int                compares = 0;
    int                cycles   = 0;

    typedef struct packed {
        logic [2:0]  code;
        logic [9:0]  dev;
        logic [4:0]  rg;
        logic [15:0] dat;
        logic        rsp;
        logic [15:0] exp;
    } otpap_row_type;

    localparam int NROWS = 11;
    localparam otpap_row_type ROWS [NROWS] = '{
        '{CMD_WRITE, 10'h000, RAM_CFG_A, A_VAL, 1'b0, 16'h0000},
        '{CMD_READ,  10'h001, RAM_CFG_A, 16'h0, 1'b1, A_VAL},
        '{CMD_READ,  10'h000, RAM_CFG_A, 16'h0, 1'b0, 16'h0000},
        '{CMD_WRITE, 10'h001, RAM_CFG_B, B_VAL, 1'b0, 16'h0000},
        '{CMD_READ,  10'h001, RAM_CFG_B, 16'h0, 1'b1, B_VAL},
        '{CMD_WRITE, 10'h002, RAM_CFG_B, 16'hffff, 1'b0, 16'h0},
        '{CMD_READ,  10'h001, RAM_CFG_B, 16'h0, 1'b1, B_VAL},
        '{CMD_READ,  10'h001, RAM_NODE_ADDR, 16'h0, 1'b1, ADDR1},
        '{CMD_READ,  10'h001, ROM_CFG_A, 16'h0, 1'b1, 16'h0000},
        '{CMD_WRITE, 10'h001, ROM_CFG_A, 16'h5555, 1'b0, 16'h0},
        '{CMD_READ,  10'h001, ROM_CFG_A, 16'h0, 1'b1, 16'h0000}
    };

    // ========================================
    // clock, design and host
    always #12.5 core_clk = ~core_clk;

    otpap_top #(
        .PROG_GAP_CYCLES (GAP)
    ) otpap_top_i (
        .core_clk_i      (core_clk),
        .rst_b_i         (rst_b),
        .fuse_blank_b_i  (fuse_blank_b),
        .cmd_i           (cmd),
        .light_pulse_i   (light),
        .vprog_ok_i      (vprog),
        .rsp_o           (rsp),
        .node_addr_o     (node_addr),
        .bus_bit_rate_o  (rate),
        .prog_busy_o     (busy),
        .assign_armed_o  (armed)
    );

    otpap_host_model #(
        .GAP_CYCLES (GAP)
    ) otpap_host_model_i (
        .core_clk_i (core_clk),
        .cmd_o      (cmd),
        .light_o    (light),
        .vprog_o    (vprog)
    );

    // ========================================
    // checking helpers
    task automatic wrap_up();
        if (n_errors == 0 && compares > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp,
                       input string what);
        compares = compares + 1;
        if (got !== exp)
        begin
            n_errors = n_errors + 1;
            $display("Error %0t: %s got %h want %h", $time, what, got, exp);
        end
    endtask

    // the answer register stands for the cycle after the taken edge
    task automatic do_cmd(input otpap_row_type r);
        otpap_host_model_i.send(r.code, r.dev, r.rg, r.dat);
        chk({15'h0, rsp.valid}, {15'h0, r.rsp}, "answer strobe");
        if (r.rsp)
        begin
            chk(rsp.data, r.exp, "read data");
            chk({11'h0, rsp.reg_addr}, {11'h0, r.rg}, "read reg");
        end
    endtask

    task automatic rd(input logic [4:0] rg, input logic [15:0] e);
        otpap_row_type r;
        r = '{CMD_READ, 10'h001, rg, 16'h0000, 1'b1, e};
        do_cmd(r);
    endtask

    always @(posedge core_clk)
    begin
        cycles <= cycles + 1;
        if (cycles == LIMIT)
        begin
            n_errors = n_errors + 1;
            $display("Error %0t: run timed out", $time);
            wrap_up();
        end
    end

    // ========================================
    // main sequence
    initial
    begin
        rst_b        = 1'b0;
        fuse_blank_b = 1'b0;
        repeat (20) @(negedge core_clk);
        fuse_blank_b = 1'b1;
        rst_b        = 1'b1;
        repeat (5) @(negedge core_clk);
        chk({6'h0, node_addr}, 16'h0000, "start address");
        chk({13'h0, rate}, {13'h0, RATE_250K}, "start rate");
        otpap_host_model_i.prepare();
        otpap_host_model_i.send(CMD_ASSIGN, 10'h000, 5'h00, 16'h0000);
        chk({15'h0, armed}, 16'h0000, "assign at zero");
        otpap_host_model_i.send(CMD_ASSIGN, 10'h001, 5'h00, 16'h0000);
        chk({15'h0, armed}, 16'h0001, "armed");
        otpap_host_model_i.flash();
        repeat (8) @(negedge core_clk);
        chk({6'h0, node_addr}, 16'h0001, "allocated address");
        chk({15'h0, armed}, 16'h0000, "disarmed");
        for (int i = 0; i < NROWS; i++)
            do_cmd(ROWS[i]);
        chk({13'h0, rate}, RATE_A, "rate field");
        chk({13'h0, otpap_host_model_i.link_rate}, RATE_A, "link rate");
        otpap_host_model_i.send(CMD_READ, otpap_host_model_i.IF_ADDR,
                                RAM_CFG_A, 16'h0000);
        chk({15'h0, rsp.valid}, 16'h0000, "interface address");
        // a second burn inside the gap must be refused, not queued
        otpap_host_model_i.supply(1'b1);
        otpap_host_model_i.send(CMD_PROG, 10'h001, ROM_CFG_A, 16'h0000);
        chk({15'h0, busy}, 16'h0001, "burn window");
        otpap_host_model_i.send(CMD_PROG, 10'h001, ROM_CFG_B, 16'h0000);
        repeat (GAP + 2) @(negedge core_clk);
        rd(ROM_CFG_B, 16'h0000);
        rd(ROM_CFG_A, A_VAL | FLAG_MASK);
        otpap_host_model_i.send(CMD_WRITE, 10'h001, RAM_CFG_A, 16'h000e);
        rd(RAM_CFG_A, A_VAL);
        otpap_host_model_i.send(CMD_PROG, 10'h001, ROM_CFG_A, 16'h0000);
        chk({15'h0, busy}, 16'h0000, "second burn");
        rd(ROM_CFG_A, A_VAL | FLAG_MASK);
        otpap_host_model_i.supply(1'b0);
        otpap_host_model_i.prog(10'h000, ROM_CFG_B);
        rd(ROM_CFG_B, 16'h0000);
        otpap_host_model_i.supply(1'b1);
        otpap_host_model_i.prog(10'h000, ROM_CFG_B);
        rd(ROM_CFG_B, B_VAL | FLAG_MASK);
        otpap_host_model_i.send(CMD_WRITE, 10'h001, RAM_CFG_C, 16'h00f0);
        otpap_host_model_i.send(3'h5, 10'h001, ROM_CFG_C, 16'h0000);
        rd(ROM_CFG_C, 16'h0000);
        otpap_host_model_i.send(CMD_PROG, 10'h001, 5'h05, 16'h0000);
        chk({15'h0, busy}, 16'h0000, "unpaired target");
        otpap_host_model_i.prog(10'h000, ROM_NODE_ADDR);
        rd(ROM_NODE_ADDR, 16'h0000);
        otpap_host_model_i.prog(10'h001, ROM_NODE_ADDR);
        rd(ROM_NODE_ADDR, ADDR1 | FLAG_MASK);
        otpap_host_model_i.send(CMD_ASSIGN, 10'h005, 5'h00, 16'h0000);
        chk({15'h0, armed}, 16'h0000, "assign after burn");
        otpap_host_model_i.flash();
        repeat (8) @(negedge core_clk);
        chk({6'h0, node_addr}, 16'h0001, "address kept");
        otpap_host_model_i.send(CMD_RESET, 10'h001, 5'h00, 16'h0000);
        repeat (4) @(negedge core_clk);
        rd(RAM_CFG_A, A_VAL | FLAG_MASK);
        rst_b = 1'b0;
        repeat (3) @(negedge core_clk);
        chk({6'h0, node_addr}, 16'h0000, "address in reset");
        rst_b = 1'b1;
        repeat (6) @(negedge core_clk);
        chk({6'h0, node_addr}, 16'h0001, "address after power up");
        chk({13'h0, rate}, RATE_A, "rate after power up");
        rd(RAM_NODE_ADDR, ADDR1 | FLAG_MASK);
        rd(RAM_CFG_B, B_VAL | FLAG_MASK);
        wrap_up();
    end
endmodule
